/* core/host_ctrl_defs.vh */
// constants for the host endpoint and power control block
`ifndef HOST_CTRL_DEFS_VH
`define HOST_CTRL_DEFS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define REG_CTRL        4'h0
`define REG_PWR_CFG     4'h1
`define REG_CMD         4'h2
`define REG_EP_SEL      4'h3
`define REG_HUB         4'h4
`define REG_EP_STATUS   4'h5
`define REG_IRQ_STATUS  4'h6
`define REG_IRQ_MASK    4'h7
`define REG_TOGGLES     4'h8
`define REG_REQUESTS    4'h9

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTRL_ROLE_BIT   0
`define CTRL_FLT_EN     1
`define CFG_FLT_HIGH    0
`define CFG_REACT_LO    1
`define CFG_REACT_HI    2
`define CFG_EN_HIGH     3
`define CFG_SESSION     4
`define CFG_FILTER      5
`define SEL_EP_LO       0
`define SEL_EP_HI       1
`define SEL_OUT         2
`define SEL_LOW_SPEED   3
`define SEL_TOGGLE_VAL  4
`define CMD_HOST_MODE   0
`define CMD_PWR_EN      1
`define CMD_PWR_DIS     2
`define CMD_TOGGLE      3
`define CMD_REQ_IN      4
`define CMD_REQ_CLR     5
`define CMD_STAT_CLR    6
`define CMD_SESSION     7
`define CMD_SESS_END    8

// fault reaction codes
`define REACT_NONE      2'h0
`define REACT_HIZ       2'h1
`define REACT_LOW       2'h2
`define REACT_HIGH      2'h3

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define PWR_CFG_RESET   6'h00
`define CLK_PERIOD_NS   100
`define GLITCH_NS       1000
`define GLITCH_CYCLES   ((`GLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GLITCH_CNT_W    4

`endif

/* core/glitch_filter.v */
// debounce filter for a synchronised level input
`timescale 1ns/1ps
`default_nettype none
`include "host_ctrl_defs.vh"

module glitch_filter
(
    // clock and reset
    input  wire        clk,
    input  wire        reset,
    input  wire        clk_en,
    // control
    input  wire        enable,
    input  wire        din,
    output reg         dout
);

    reg [`GLITCH_CNT_W-1:0] count;

    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            count <= {`GLITCH_CNT_W{1'b0}};
            dout  <= 1'b1;
        end
        else if (clk_en)
        begin
            if (!enable || din == dout)
            begin
                count <= {`GLITCH_CNT_W{1'b0}};
                if (!enable)
                    dout <= din;
            end
            else if (count == `GLITCH_CYCLES - 1)
            begin
                count <= {`GLITCH_CNT_W{1'b0}};
                dout  <= din;
            end
            else
                count <= count + 1'b1;
        end
    end

endmodule

`default_nettype wire

/* core/usb_host_endpoint_power_ctrl.v */
// host endpoint toggle, hub routing, IN request and supply power control
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "host_ctrl_defs.vh"

module usb_host_endpoint_power_ctrl
(
    // clock and reset
    input  wire        clk,
    input  wire        reset,
    input  wire        clk_en,
    // register port
    input  wire [3:0]  addr,
    input  wire [15:0] wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [15:0] rdata,
    // link engine events
    input  wire [3:0]  done_ep,
    input  wire        done_out,
    input  wire        done_pulse,
    input  wire [7:0]  status_set_in,
    input  wire [3:0]  status_set_ep,
    input  wire        status_set_pulse,
    // pins
    input  wire        power_fault_input,
    input  wire        vbus_valid_pin,
    output reg         supply_enable_output,
    output reg         supply_enable_oe,
    output reg         vbus_error,
    // role and interrupt
    output reg         role_select_bit,
    output reg         irq
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    reg        fault_detect_en;
    reg [5:0]  pwr_cfg;
    reg [4:0]  ep_sel;
    reg [3:0]  toggle_in;
    reg [3:0]  toggle_out;
    reg [3:0]  req_in;
    reg [7:0]  ep_status [0:3];
    reg [14:0] hub_in    [0:3];
    reg [14:0] hub_out   [0:3];
    reg [3:0]  low_speed_in;
    reg [3:0]  low_speed_out;
    reg        power_on;
    reg        session_on;
    reg        fault_latched;
    reg [2:0]  irq_status;
    reg [2:0]  irq_mask;
    reg        flt_s1;
    reg        flt_s2;
    reg        vb_s1;
    reg        vb_s2;
    reg        vb_prev;
    wire       vb_filt;

    wire [1:0] sel = ep_sel[`SEL_EP_HI:`SEL_EP_LO];
    wire       sel_out = ep_sel[`SEL_OUT];
    wire       do_wr = clk_en & wr;
    wire [15:0] cmd = (do_wr && addr == `REG_CMD) ? wdata : 16'h0000;
    wire [1:0] react = pwr_cfg[`CFG_REACT_HI:`CFG_REACT_LO];

    function [3:0] one_hot;
        input [1:0] n;
        begin
            one_hot = 4'h1 << n;
        end
    endfunction

    // ------------------------------------------------------------
    // strobe decode
    // ------------------------------------------------------------
    // one decode per register keeps every process on the same strobe
    wire       wr_ctrl    = do_wr && addr == `REG_CTRL;
    wire       wr_pwr_cfg = do_wr && addr == `REG_PWR_CFG;
    wire       wr_ep_sel  = do_wr && addr == `REG_EP_SEL;
    wire       wr_hub     = do_wr && addr == `REG_HUB;
    wire       wr_irq_clr = do_wr && addr == `REG_IRQ_STATUS;
    wire       wr_irq_msk = do_wr && addr == `REG_IRQ_MASK;
    // out-of-range endpoint codes select nothing
    wire [3:0] sel_hot    = one_hot(sel);
    wire [3:0] done_hot   = (done_ep[3:2] == 2'b00) ? one_hot(done_ep[1:0]) : 4'h0;
    wire [3:0] stat_hot   = (status_set_ep[3:2] == 2'b00) ? one_hot(status_set_ep[1:0]) : 4'h0;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            flt_s1 <= 1'b0;
            flt_s2 <= 1'b0;
            vb_s1  <= 1'b1;
            vb_s2  <= 1'b1;
        end
        else if (clk_en)
        begin
            flt_s1 <= power_fault_input;
            flt_s2 <= flt_s1;
            vb_s1  <= vbus_valid_pin;
            vb_s2  <= vb_s1;
        end
    end

    glitch_filter u_filter
    (
        .clk    (clk),
        .reset  (reset),
        .clk_en (clk_en),
        .enable (pwr_cfg[`CFG_FILTER]),
        .din    (vb_s2),
        .dout   (vb_filt)
    );

    wire fault_now = fault_detect_en &
                     (pwr_cfg[`CFG_FLT_HIGH] ? flt_s2 : ~flt_s2);
    wire vbus_drop = vb_prev & ~vb_filt;

    // ------------------------------------------------------------
    // control and power
    // ------------------------------------------------------------
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            role_select_bit <= 1'b0;
            fault_detect_en <= 1'b0;
            pwr_cfg         <= `PWR_CFG_RESET;
            ep_sel          <= 5'h00;
        end
        else if (clk_en)
        begin
            if (wr_ctrl)
            begin
                fault_detect_en <= wdata[`CTRL_FLT_EN];
                role_select_bit <= wdata[`CTRL_ROLE_BIT];
            end
            if (cmd[`CMD_HOST_MODE])
                role_select_bit <= 1'b1;
            if (wr_pwr_cfg)
                pwr_cfg <= wdata[5:0];
            if (wr_ep_sel)
                ep_sel <= wdata[4:0];
        end
    end

    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            power_on      <= 1'b0;
            session_on    <= 1'b0;
            fault_latched <= 1'b0;
        end
        else if (clk_en)
        begin
            if (cmd[`CMD_PWR_DIS])
                power_on <= 1'b0;
            else if (cmd[`CMD_PWR_EN])
                power_on <= 1'b1;
            if (cmd[`CMD_SESS_END])
                session_on <= 1'b0;
            else if (cmd[`CMD_SESSION])
                session_on <= 1'b1;
            // fault holds until a power enable or disable command, or until detection is switched off
            if (fault_now)
                fault_latched <= 1'b1;
            else if (cmd[`CMD_PWR_EN] || cmd[`CMD_PWR_DIS] || !fault_detect_en)
                fault_latched <= 1'b0;
        end
    end

    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            vb_prev    <= 1'b1;
            vbus_error <= 1'b0;
        end
        else if (clk_en)
        begin
            vb_prev <= vb_filt;
            // filtered level feeds the error flag
            vbus_error <= ~vb_filt & role_select_bit;
        end
    end

    wire want_on = pwr_cfg[`CFG_SESSION] ? session_on : power_on;
    wire act_lvl = pwr_cfg[`CFG_EN_HIGH];

    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            supply_enable_output <= 1'b0;
            supply_enable_oe     <= 1'b0;
        end
        else if (clk_en)
        begin
            if (fault_latched && react != `REACT_NONE)
            begin
                supply_enable_output <= (react == `REACT_HIGH);
                supply_enable_oe     <= (react != `REACT_HIZ);
            end
            else
            begin
                supply_enable_output <= want_on ? act_lvl : ~act_lvl;
                supply_enable_oe     <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // endpoints
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : gen_ep
            wire hit      = sel_hot[g];
            wire done_hit = done_pulse && done_hot[g];
            wire force_in  = cmd[`CMD_TOGGLE] && hit && (g == 0 || !sel_out);
            wire force_out = cmd[`CMD_TOGGLE] && hit && (g == 0 || sel_out);
            always @(posedge clk or posedge reset)
            begin
                if (reset)
                begin
                    toggle_in[g]     <= 1'b0;
                    toggle_out[g]    <= 1'b0;
                    req_in[g]        <= 1'b0;
                    ep_status[g]     <= 8'h00;
                    hub_in[g]        <= 15'h0000;
                    hub_out[g]       <= 15'h0000;
                    low_speed_in[g]  <= 1'b0;
                    low_speed_out[g] <= 1'b0;
                end
                else if (clk_en)
                begin
                    if (force_in)
                        toggle_in[g] <= ep_sel[`SEL_TOGGLE_VAL];
                    else if (done_hit && !done_out)
                        toggle_in[g] <= ~toggle_in[g];
                    if (force_out)
                        toggle_out[g] <= ep_sel[`SEL_TOGGLE_VAL];
                    else if (done_hit && done_out)
                        toggle_out[g] <= ~toggle_out[g];
                    if (cmd[`CMD_REQ_IN] && hit)
                        req_in[g] <= 1'b1;
                    else if ((cmd[`CMD_REQ_CLR] && hit) || (done_hit && !done_out))
                        req_in[g] <= 1'b0;
                    ep_status[g] <= (ep_status[g] &
                        ~((cmd[`CMD_STAT_CLR] && hit) ? wdata[15:8] : 8'h00)) |
                        ((status_set_pulse && stat_hot[g]) ? status_set_in : 8'h00);
                    if (wr_hub && hit)
                    begin
                        if (sel_out)
                        begin
                            hub_out[g]       <= {wdata[15:8], wdata[6:0]};
                            low_speed_out[g] <= ep_sel[`SEL_LOW_SPEED];
                        end
                        else
                        begin
                            hub_in[g]        <= {wdata[15:8], wdata[6:0]};
                            low_speed_in[g]  <= ep_sel[`SEL_LOW_SPEED];
                        end
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // interrupts: fault, vbus drop, transaction done
    // ------------------------------------------------------------
    wire [2:0] irq_events = {done_pulse, vbus_drop & role_select_bit, fault_now};

    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            irq_status <= 3'h0;
            irq_mask   <= 3'h0;
            irq        <= 1'b0;
        end
        else if (clk_en)
        begin
            // set wins over write-one-to-clear
            irq_status <= (irq_status &
                ~(wr_irq_clr ? wdata[2:0] : 3'h0)) | irq_events;
            if (wr_irq_msk)
                irq_mask <= wdata[2:0];
            irq <= |(irq_status & irq_mask);
        end
    end

    // ------------------------------------------------------------
    // read back
    // ------------------------------------------------------------
    wire [14:0] hub_rd = sel_out ? hub_out[sel] : hub_in[sel];
    wire        ls_rd  = sel_out ? low_speed_out[sel] : low_speed_in[sel];

    always @(posedge clk or posedge reset)
    begin
        if (reset)
            rdata <= 16'h0000;
        else if (clk_en)
        begin
            rdata <= 16'h0000;
            if (rd)
            begin
                case (addr)
                    `REG_CTRL:       rdata <= {14'h0000, fault_detect_en, role_select_bit};
                    `REG_PWR_CFG:    rdata <= {10'h000, pwr_cfg};
                    `REG_EP_SEL:     rdata <= {11'h000, ep_sel};
                    `REG_HUB:        rdata <= {hub_rd[14:7], ls_rd, hub_rd[6:0]};
                    `REG_EP_STATUS:  rdata <= {8'h00, ep_status[sel]};
                    `REG_IRQ_STATUS: rdata <= {13'h0000, irq_status};
                    `REG_IRQ_MASK:   rdata <= {13'h0000, irq_mask};
                    `REG_TOGGLES:    rdata <= {8'h00, toggle_out, toggle_in};
                    `REG_REQUESTS:   rdata <= {9'h000, fault_latched, session_on,
                                               power_on, req_in};
                    default:         rdata <= 16'h0000;
                endcase
            end
        end
    end

endmodule

`default_nettype wire

/* sim/usb_host_endpoint_power_ctrl_checker.sv */
// port-level assertions for the host endpoint power control block
`timescale 1ns/1ps
`default_nettype none
`include "host_ctrl_defs.vh"
module usb_host_endpoint_power_ctrl_checker
(
    // clock and reset
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        clk_en,
    // register port
    input wire logic [3:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [15:0] rdata,
    // pins and role
    input wire logic        supply_enable_output,
    input wire logic        supply_enable_oe,
    input wire logic        vbus_error,
    input wire logic        role_select_bit
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // shadow of the settings the pin levels depend on
    logic [5:0] cfg;
    logic       detect;
    always_ff @(posedge clk or posedge reset)
        if (reset)
        begin
            cfg    <= 6'h00;
            detect <= 1'b0;
        end
        else if (clk_en && wr && addr == `REG_PWR_CFG)
            cfg <= wdata[5:0];
        else if (clk_en && wr && addr == `REG_CTRL)
            detect <= wdata[`CTRL_FLT_EN];
    sequence cmd(int b);
        clk_en && wr && addr == `REG_CMD && wdata[b];
    endsequence
    sequence quiet;
        !detect && !wdata[`CMD_PWR_DIS];
    endsequence
    a_rdata_idle: assert property (
        !$past(rd) |-> rdata == 16'h0000) else $error("read data outside read slot");
    a_unmapped_zero: assert property (
        rd && addr > `REG_REQUESTS |=> rdata == 16'h0000) else $error("unmapped read not zero");
    a_cfg_readback: assert property (
        rd && addr == `REG_PWR_CFG |=> rdata[5:0] == $past(cfg)) else $error("config readback");
    a_role_set: assert property (
        cmd(`CMD_HOST_MODE) |=> role_select_bit) else $error("host role not set");
    a_role_clear: assert property (
        $fell(role_select_bit) |-> $past(clk_en) && $past(wr) && $past(addr) == `REG_CTRL
        && !$past(wdata[`CTRL_ROLE_BIT]))
        else $error("host role lost");
    a_pwr_off: assert property (
        (cmd(`CMD_PWR_DIS) ##0 !detect && !cfg[4]) |-> ##2 supply_enable_oe
        && supply_enable_output == !cfg[3]) else $error("supply not off");
    a_pwr_on: assert property (
        (cmd(`CMD_PWR_EN) ##0 quiet ##0 !cfg[4]) |-> ##2 supply_enable_oe
        && supply_enable_output == cfg[3]) else $error("supply not on");
    a_session_on: assert property (
        (cmd(`CMD_SESSION) ##0 quiet ##0 cfg[4] && !wdata[`CMD_SESS_END]) |-> ##2
        supply_enable_output == cfg[3]) else $error("session supply not on");
    a_hiz_only: assert property (
        $fell(supply_enable_oe) |-> cfg[2:1] == `REACT_HIZ) else $error("pin released");
    a_vbus_host: assert property (
        !role_select_bit && !$past(role_select_bit) |-> !vbus_error)
        else $error("vbus error outside host role");
endmodule
`default_nettype wire

/* sim/usb_link_partner.sv */
// model of the link engine and the supply pins beside the block
`timescale 1ns/1ps
`default_nettype none
module usb_link_partner
(
    // clock
    input  wire logic       clk,
    // transaction and status events
    output var logic [3:0]  done_ep,
    output var logic        done_out,
    output var logic        done_pulse,
    output var logic [7:0]  status_set_in,
    output var logic [3:0]  status_set_ep,
    output var logic        status_set_pulse,
    // pins
    output var logic        power_fault_input,
    output var logic        vbus_valid_pin
);
    // fault pin stays inactive until a fault is commanded
    initial
    begin
        {done_ep, done_out, done_pulse} = 6'h00;
        {status_set_in, status_set_ep, status_set_pulse} = 13'h0000;
        power_fault_input = 1'b1;
        vbus_valid_pin = 1'b1;
    end
    // qualifiers inverted outside the pulse so stale values are never trusted
    task automatic complete(input logic [3:0] ep, input logic out);
        @(posedge clk);
        {done_ep, done_out, done_pulse} <= {ep, out, 1'b1};
        @(posedge clk);
        {done_ep, done_out, done_pulse} <= {~ep, ~out, 1'b0};
    endtask
    task automatic set_status(input logic [3:0] ep, input logic [7:0] bits);
        @(posedge clk);
        {status_set_in, status_set_ep, status_set_pulse} <= {bits, ep, 1'b1};
        @(posedge clk);
        {status_set_in, status_set_ep, status_set_pulse} <= {~bits, ~ep, 1'b0};
    endtask
    task automatic fault(input logic lvl);
        @(posedge clk);
        power_fault_input <= lvl;
    endtask
    task automatic dip(input int n);
        @(posedge clk);
        vbus_valid_pin <= 1'b0;
        repeat (n) @(posedge clk);
        vbus_valid_pin <= 1'b1;
    endtask
endmodule
`default_nettype wire

/* sim/usb_host_endpoint_power_ctrl_bench.sv */
// self-checking bench for the host endpoint power control block
`timescale 1ns/1ps
`default_nettype none
`include "host_ctrl_defs.vh"
module usb_host_endpoint_power_ctrl_bench;
    logic        clk, reset, clk_en, wr, rd, done_out, done_pulse, status_set_pulse;
    logic [3:0]  addr, done_ep, status_set_ep;
    logic [15:0] wdata, rdata;
    logic [7:0]  status_set_in;
    logic        power_fault_input, vbus_valid_pin, supply_enable_output;
    logic        supply_enable_oe, vbus_error, role_select_bit, irq, seen;
    int          error_cnt, comparisons;
    logic [1:0]  exp_p [4] = '{2'h3, 2'h0, 2'h2, 2'h3};
    usb_host_endpoint_power_ctrl usb_host_endpoint_power_ctrl_i (.clk(clk), .reset(reset),
        .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .done_ep(done_ep), .done_out(done_out), .done_pulse(done_pulse),
        .status_set_in(status_set_in), .status_set_ep(status_set_ep),
        .status_set_pulse(status_set_pulse), .power_fault_input(power_fault_input),
        .vbus_valid_pin(vbus_valid_pin), .supply_enable_output(supply_enable_output),
        .supply_enable_oe(supply_enable_oe), .vbus_error(vbus_error),
        .role_select_bit(role_select_bit), .irq(irq));
    usb_link_partner usb_link_partner_i (.clk(clk), .done_ep(done_ep), .done_out(done_out),
        .done_pulse(done_pulse), .status_set_in(status_set_in),
        .status_set_ep(status_set_ep), .status_set_pulse(status_set_pulse),
        .power_fault_input(power_fault_input), .vbus_valid_pin(vbus_valid_pin));
    always #50 clk = ~clk;
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge clk);
        {addr, rd} <= {a, 1'b1};
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata & m, e);
    endtask
    task automatic cmd(input logic [15:0] d);
        wreg(`REG_CMD, d);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // hi-z leaves the level meaningless, so it is masked by the enable
    task automatic pins(input logic [1:0] e);
        chk({14'h0000, supply_enable_oe, supply_enable_output & supply_enable_oe}, {14'h0000, e});
    endtask
    task automatic t_basic;
        for (int a = 0; a < 16; a++)
            rchk(a[3:0], 16'hFFFF, 16'h0000);
        cmd(16'h0001);
        idle(1);
        chk({15'h0000, role_select_bit}, 16'h0001);
        wreg(`REG_CTRL, 16'h0000);
        rchk(`REG_CTRL, 16'h0001, 16'h0000);
        cmd(16'h0001);
        rchk(`REG_CTRL, 16'h0001, 16'h0001);
        wreg(`REG_EP_SEL, 16'h0015);
        cmd(16'h0008);
        rchk(`REG_TOGGLES, 16'h00FF, 16'h0020);
        wreg(`REG_EP_SEL, 16'h0014);
        cmd(16'h0008);
        rchk(`REG_TOGGLES, 16'h00FF, 16'h0031);
        wreg(`REG_EP_SEL, 16'h0005);
        cmd(16'h0008);
        rchk(`REG_TOGGLES, 16'h00FF, 16'h0011);
        wreg(`REG_EP_SEL, 16'h000A);
        wreg(`REG_HUB, 16'hA57F);
        wreg(`REG_EP_SEL, 16'h0006);
        wreg(`REG_HUB, 16'h1203);
        rchk(`REG_HUB, 16'hFFFF, 16'h1203);
        wreg(`REG_EP_SEL, 16'h0002);
        rchk(`REG_HUB, 16'hFFFF, 16'hA5FF);
        $display("registers, toggle and hub test done");
    endtask
    task automatic t_endpoint;
        usb_link_partner_i.set_status(4'h1, 8'hFF);
        usb_link_partner_i.set_status(4'h2, 8'h3C);
        wreg(`REG_EP_SEL, 16'h0001);
        cmd(16'h0F40);
        rchk(`REG_EP_STATUS, 16'h00FF, 16'h00F0);
        wreg(`REG_EP_SEL, 16'h0002);
        rchk(`REG_EP_STATUS, 16'h00FF, 16'h003C);
        wreg(`REG_EP_SEL, 16'h0001);
        cmd(16'h0010);
        rchk(`REG_REQUESTS, 16'h000F, 16'h0002);
        cmd(16'h0020);
        rchk(`REG_REQUESTS, 16'h000F, 16'h0000);
        cmd(16'h0010);
        usb_link_partner_i.complete(4'h1, 1'b0);
        rchk(`REG_REQUESTS, 16'h000F, 16'h0000);
        rchk(`REG_TOGGLES, 16'h00FF, 16'h0013);
        cmd(16'h0010);
        usb_link_partner_i.complete(4'h1, 1'b1);
        rchk(`REG_TOGGLES, 16'h00FF, 16'h0033);
        rchk(`REG_REQUESTS, 16'h000F, 16'h0002);
        cmd(16'h0020);
        chk({15'h0000, irq}, 16'h0000);
        wreg(`REG_IRQ_MASK, 16'h0004);
        idle(2);
        chk({15'h0000, irq}, 16'h0001);
        wreg(`REG_IRQ_STATUS, 16'h0004);
        idle(2);
        chk({15'h0000, irq}, 16'h0000);
        $display("endpoint status, request and interrupt test done");
    endtask
    // strobes and events while frozen must leave no trace
    task automatic t_freeze;
        @(posedge clk);
        clk_en <= 1'b0;
        wreg(`REG_CTRL, 16'h0000);
        cmd(16'h0010);
        usb_link_partner_i.complete(4'h1, 1'b1);
        @(posedge clk);
        clk_en <= 1'b1;
        idle(1);
        chk({15'h0000, role_select_bit}, 16'h0001);
        rchk(`REG_REQUESTS, 16'h000F, 16'h0000);
        rchk(`REG_TOGGLES, 16'h00FF, 16'h0033);
        $display("clock enable freeze test done");
    endtask
    task automatic t_power;
        pins(2'h3);
        cmd(16'h0002);
        idle(3);
        pins(2'h2);
        cmd(16'h0004);
        idle(3);
        pins(2'h3);
        for (int r = 0; r < 4; r++)
        begin
            wreg(`REG_PWR_CFG, 16'h0008 | 16'(r << 1));
            wreg(`REG_CTRL, 16'h0003);
            cmd(16'h0002);
            idle(3);
            pins(2'h3);
            usb_link_partner_i.fault(1'b0);
            idle(8);
            pins(exp_p[r]);
            rchk(`REG_IRQ_STATUS, 16'h0001, 16'h0001);
            usb_link_partner_i.fault(1'b1);
            wreg(`REG_CTRL, 16'h0001);
            wreg(`REG_IRQ_STATUS, 16'h0001);
            cmd(16'h0004);
        end
        wreg(`REG_PWR_CFG, 16'h000D);
        usb_link_partner_i.fault(1'b0);
        cmd(16'h0002);
        usb_link_partner_i.fault(1'b1);
        idle(8);
        pins(2'h3);
        wreg(`REG_CTRL, 16'h0003);
        idle(8);
        pins(2'h2);
        wreg(`REG_CTRL, 16'h0001);
        cmd(16'h0004);
        idle(3);
        pins(2'h2);
        wreg(`REG_PWR_CFG, 16'h0018);
        cmd(16'h0080);
        idle(3);
        pins(2'h3);
        cmd(16'h0100);
        idle(3);
        pins(2'h2);
        $display("power and fault test done");
    endtask
    task automatic t_filter(input logic [15:0] c, input logic e);
        wreg(`REG_PWR_CFG, c);
        idle(12);
        seen = 1'b0;
        fork
            usb_link_partner_i.dip(3);
            repeat (16)
            begin
                @(posedge clk);
                #1 seen = seen | vbus_error;
            end
        join
        chk({15'h0000, seen}, {15'h0000, e});
        $display("vbus filter test done");
    endtask
    initial
    begin
        {clk, reset, addr, wdata, wr, rd, error_cnt, comparisons} = '0;
        clk_en = 1'b1;
        reset = 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        t_basic();
        t_endpoint();
        t_freeze();
        t_power();
        t_filter(16'h0020, 1'b0);
        t_filter(16'h0000, 1'b1);
        stop_test();
    end
    initial
    begin
        #500000;
        error_cnt++;
        stop_test();
    end
endmodule
bind usb_host_endpoint_power_ctrl usb_host_endpoint_power_ctrl_checker chk_i (.clk(clk),
    .reset(reset), .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .supply_enable_output(supply_enable_output),
    .supply_enable_oe(supply_enable_oe), .vbus_error(vbus_error),
    .role_select_bit(role_select_bit));
`default_nettype wire
